// ===== logic/dual_modulus_prescaler_5_6.sv
// dual modulus divide by five or six counter
// Behaviour
// [RULE1] divide by five if either select high
// [RULE2] divide by six when both selects low
// [RULE3] six states, extra all-high state skipped under five
// [RULE4] true and inverted divided outputs
// [RULE5] fixed five: feed inverted output back
// [RULE6] undriven selects read low, six; the code has no pull-down, only reset loads six
// [RULE7] controller updates selects within about 13ns
// [RULE8] cascaded ten/twelve loop allows about 33ns
// [RULE9] sample selects once before extra state
`timescale 1ns/1ps
module dual_modulus_prescaler_5_6 (
   // clock and reset, i_clk_sys is the count clock input
   input  wire logic                      i_clk_sys,
   input  wire logic                      i_rst,
   // ratio selects, tie low when unused
   input  wire prescaler_pkg::ratio_sel_t i_ratio_sel,
   // divided outputs
   output prescaler_pkg::div_out_t        o_div,
   output prescaler_pkg::stage_t          o_stage
);
   import prescaler_pkg::*;

   typedef enum {ST_S1, ST_S2, ST_S3, ST_S4, ST_S5, ST_EXTRA} seq_state_t;

   seq_state_t state;
   seq_state_t next_state;
   stage_t     stage;
   stage_t     next_stage;
   div_out_t   div;
   modulus_t   modulus;
   wire        sample_pt;

   // stage pattern for each sequence state
   function automatic stage_t stage_of(input seq_state_t s);
      case (s)
         ST_S1:    stage_of = SEQ_STEP1;
         ST_S2:    stage_of = SEQ_STEP2;
         ST_S3:    stage_of = SEQ_STEP3;
         ST_S4:    stage_of = SEQ_STEP4;
         ST_S5:    stage_of = SEQ_STEP5;
         ST_EXTRA: stage_of = SEQ_EXTRA;
         default:  stage_of = SEQ_START;
      endcase
   endfunction

   // sample at step four, so the choice governs the step after step five
   assign sample_pt = (state == ST_S4); // RULE9

   ratio_sampler ratio_sampler_inst (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_sample  (sample_pt),
      .i_sel     (i_ratio_sel),
      .o_modulus (modulus)
   );

   // next state; five skips the extra state
   always_comb begin
      case (state)
         ST_S1:    next_state = ST_S2; // RULE3
         ST_S2:    next_state = ST_S3;
         ST_S3:    next_state = ST_S4;
         ST_S4:    next_state = ST_S5;
         ST_S5:    next_state = (modulus == MOD_FIVE) ? ST_S1 : ST_EXTRA; // RULE1 RULE2
         ST_EXTRA: next_state = ST_S1;
         default:  next_state = ST_S1;
      endcase
   end

   assign next_stage = stage_of(next_state);

   // state register; no documented reset, a start point is still needed
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state <= ST_S1;
         stage <= SEQ_START;
      end else begin
         state <= next_state;
         stage <= next_stage;
      end
   end

   // outputs from the first stage, registered for a clean edge
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         div.true_out <= SEQ_START[STAGE_FIRST_BIT];
         div.inv_out  <= ~SEQ_START[STAGE_FIRST_BIT];
      end else begin
         div.true_out <= next_stage[STAGE_FIRST_BIT]; // RULE4
         div.inv_out  <= ~next_stage[STAGE_FIRST_BIT]; // RULE4
      end
   end

   assign o_div   = div;
   assign o_stage = stage;

   // checks; the first stage is high from step four to the end of a cycle, three steps under six, two under five
   wire high_half;
   int  run_len;

   assign high_half = (state == ST_S4) | (state == ST_S5) | (state == ST_EXTRA); // RULE4
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         run_len <= 0;
      end else if (state == ST_S1) begin
         run_len <= 1;
      end else begin
         run_len <= run_len + 1;
      end
   end

   property p_order_s1;
      @(posedge i_clk_sys) disable iff (i_rst) state == ST_S1 |=> state == ST_S2;
   endproperty
   a_order_s1: assert property (p_order_s1) else $error("s1 not followed by s2"); // RULE3

   property p_stage_patterns;
      @(posedge i_clk_sys) disable iff (i_rst)
         state == ST_S2 |-> stage == SEQ_STEP2 ##1 stage == SEQ_STEP3 ##1 stage == SEQ_STEP4;
   endproperty
   a_stage_patterns: assert property (p_stage_patterns) else $error("stage pattern wrong"); // RULE3

   property p_five;
      @(posedge i_clk_sys) disable iff (i_rst)
         state == ST_S5 && modulus == MOD_FIVE |=> state == ST_S1;
   endproperty
   a_five: assert property (p_five) else $error("five did not skip extra"); // RULE1

   property p_six;
      @(posedge i_clk_sys) disable iff (i_rst)
         state == ST_S5 && modulus == MOD_SIX |=> state == ST_EXTRA ##1 state == ST_S1;
   endproperty
   a_six: assert property (p_six) else $error("six did not use extra"); // RULE2

   property p_sel_five;
      @(posedge i_clk_sys) disable iff (i_rst)
         state == ST_S4 && (i_ratio_sel.sel_a || i_ratio_sel.sel_b) |=> ##1 state == ST_S1;
   endproperty
   a_sel_five: assert property (p_sel_five) else $error("high select gave no five"); // RULE9

   property p_sel_six;
      @(posedge i_clk_sys) disable iff (i_rst)
         state == ST_S4 && !i_ratio_sel.sel_a && !i_ratio_sel.sel_b |=> ##1 state == ST_EXTRA;
   endproperty
   a_sel_six: assert property (p_sel_six) else $error("low selects gave no six"); // RULE6

   property p_complement;
      @(posedge i_clk_sys) disable iff (i_rst) o_div.inv_out == !o_div.true_out;
   endproperty
   a_complement: assert property (p_complement) else $error("outputs not complementary"); // RULE4

   property p_out_tracks;
      @(posedge i_clk_sys) disable iff (i_rst) o_div.true_out == stage[STAGE_FIRST_BIT];
   endproperty
   a_out_tracks: assert property (p_out_tracks) else $error("output not first stage"); // RULE4

   property p_cycle_len;
      @(posedge i_clk_sys) disable iff (i_rst)
         state == ST_S1 && $past(state) != ST_S1 && run_len != 0 |-> run_len inside {DIV_FIVE, DIV_SIX};
   endproperty
   a_cycle_len: assert property (p_cycle_len) else $error("cycle length not five or six"); // RULE1

   property p_cycle_exact;
      @(posedge i_clk_sys) disable iff (i_rst)
         state == ST_S1 && run_len != 0 |-> run_len == ((modulus == MOD_FIVE) ? DIV_FIVE : DIV_SIX);
   endproperty
   a_cycle_exact: assert property (p_cycle_exact) else $error("cycle length not the sampled modulus"); // RULE1 RULE2

   property p_run_bound;
      @(posedge i_clk_sys) disable iff (i_rst)
         run_len <= DIV_SIX;
   endproperty
   a_run_bound: assert property (p_run_bound) else $error("cycle longer than six"); // RULE2

   property p_extra_exit;
      @(posedge i_clk_sys) disable iff (i_rst)
         state == ST_EXTRA |=> state == ST_S1;
   endproperty
   a_extra_exit: assert property (p_extra_exit) else $error("extra state not followed by s1"); // RULE3

   property p_stage_state;
      @(posedge i_clk_sys) disable iff (i_rst)
         stage == stage_of(state);
   endproperty
   a_stage_state: assert property (p_stage_state) else $error("stage pattern does not match state"); // RULE3

   property p_extra_only_six;
      @(posedge i_clk_sys) disable iff (i_rst)
         state == ST_EXTRA |-> modulus == MOD_SIX;
   endproperty
   a_extra_only_six: assert property (p_extra_only_six) else $error("extra state entered under five"); // RULE2

   property p_high_half;
      @(posedge i_clk_sys) disable iff (i_rst)
         o_div.true_out == high_half;
   endproperty
   a_high_half: assert property (p_high_half) else $error("true output not high in last steps"); // RULE4

   property p_inv_half;
      @(posedge i_clk_sys) disable iff (i_rst)
         o_div.inv_out == !high_half;
   endproperty
   a_inv_half: assert property (p_inv_half) else $error("inverted output not low in last steps"); // RULE4

   property p_modulus_hold;
      @(posedge i_clk_sys) disable iff (i_rst)
         !sample_pt |=> $stable(modulus);
   endproperty
   a_modulus_hold: assert property (p_modulus_hold) else $error("modulus changed off the sample point"); // RULE9

   property p_sample_once;
      @(posedge i_clk_sys) disable iff (i_rst)
         sample_pt |=> !sample_pt;
   endproperty
   a_sample_once: assert property (p_sample_once) else $error("sample point held for two cycles"); // RULE9

   property p_sel_ignored;
      @(posedge i_clk_sys) disable iff (i_rst)
         state == ST_S5 && modulus == MOD_SIX && (i_ratio_sel.sel_a || i_ratio_sel.sel_b) |=> state == ST_EXTRA;
   endproperty
   a_sel_ignored: assert property (p_sel_ignored) else $error("late select shortened the cycle"); // RULE9
endmodule // dual_modulus_prescaler_5_6

// ===== logic/prescaler_pkg.sv
// shared constants and types for the five/six prescaler
package prescaler_pkg;
   // three state stages, first stage is bit 2
   typedef logic [2:0] stage_t;

   // count sequence in divide-by-six order, L=0 H=1
   localparam stage_t SEQ_STEP1 = 3'h3; // L H H
   localparam stage_t SEQ_STEP2 = 3'h1; // L L H
   localparam stage_t SEQ_STEP3 = 3'h0; // L L L
   localparam stage_t SEQ_STEP4 = 3'h4; // H L L
   localparam stage_t SEQ_STEP5 = 3'h6; // H H L
   localparam stage_t SEQ_EXTRA = 3'h7; // H H H, the extra state
   localparam stage_t SEQ_START = SEQ_STEP1;

   // stage bit positions
   localparam int STAGE_FIRST_BIT  = 2;
   localparam int STAGE_SECOND_BIT = 1;
   localparam int STAGE_THIRD_BIT  = 0;

   // moduli
   localparam int DIV_FIVE = 5;
   localparam int DIV_SIX  = 6;

   // ratio-select pair as carried between modules
   typedef struct packed {
      logic sel_a;
      logic sel_b;
   } ratio_sel_t;

   // divided output pair
   typedef struct packed {
      logic true_out;
      logic inv_out;
   } div_out_t;

   // modulus choice
   typedef enum logic {MOD_SIX, MOD_FIVE} modulus_t;
endpackage

// ===== logic/ratio_sampler.sv
// samples the ratio-select pair once per output cycle
`timescale 1ns/1ps
module ratio_sampler (
   // clock and reset
   input  wire logic                      i_clk_sys,
   input  wire logic                      i_rst,
   // control
   input  wire logic                      i_sample,
   input  wire prescaler_pkg::ratio_sel_t i_sel,
   // result
   output prescaler_pkg::modulus_t        o_modulus
);
   import prescaler_pkg::*;

   modulus_t modulus;
   wire      sel_five;

   // either input high picks five, both low picks six
   assign sel_five = i_sel.sel_a | i_sel.sel_b; // RULE1 RULE2

   // latch only at the sample point so mid-cycle changes cannot shorten a cycle
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         modulus <= MOD_SIX; // RULE6
      end else if (i_sample) begin
         modulus <= sel_five ? MOD_FIVE : MOD_SIX; // RULE9
      end
   end

   assign o_modulus = modulus;
endmodule // ratio_sampler

// ===== bench/ratio_ctrl.sv
// model of the divider that drives the ratio selects
`timescale 1ns/1ps
module ratio_ctrl (
   // clock and stimulus
   input  wire logic                    i_clk_sys,
   input  wire logic [1:0]              i_mode,
   input  wire logic [1:0]              i_rnd,
   // feedback and selects
   input  wire prescaler_pkg::div_out_t i_div,
   output prescaler_pkg::ratio_sel_t    o_sel
);
   import prescaler_pkg::*;
   // answers one edge later, 50ns on this clock, beyond the about 13ns update bound
   always_ff @(posedge i_clk_sys) begin
      case (i_mode)
         2'h0: o_sel <= 2'h0;
         2'h1: o_sel <= i_rnd;
         2'h2: o_sel <= {i_div.inv_out, 1'b0};
         default: o_sel <= 2'h3;
      endcase
   end
endmodule // ratio_ctrl

// ===== bench/testbench.sv
// self-checking bench for the five/six prescaler
`timescale 1ns/1ps
module testbench;
   import prescaler_pkg::*;
   logic        i_clk_sys = 1'b0;
   logic        i_rst     = 1'b1;
   logic [1:0]  mode      = 2'h0;
   logic [1:0]  rnd       = 2'h0;
   logic [31:0] lfsr      = 32'h93A8C577;
   ratio_sel_t  sel;
   div_out_t    div;
   stage_t      stage;
   stage_t      exp_stage = SEQ_START;
   logic        five      = 1'b0;
   stage_t      q[$];
   int          n_fail    = 0;
   int          samples_checked = 0;
   dual_modulus_prescaler_5_6 dual_modulus_prescaler_5_6_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_ratio_sel(sel), .o_div(div), .o_stage(stage));
   ratio_ctrl ratio_ctrl_inst (.i_clk_sys(i_clk_sys), .i_mode(mode), .i_rnd(rnd), .i_div(div), .o_sel(sel));
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   initial begin
      forever #25 i_clk_sys = ~i_clk_sys;
   end
   // reference sequence, one note per edge; reset drops stale notes
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         exp_stage = SEQ_START;
         five = 1'b0;
         q.delete();
         q.push_back(SEQ_START);
      end else begin
         case (exp_stage)
            SEQ_STEP1: exp_stage = SEQ_STEP2;
            SEQ_STEP2: exp_stage = SEQ_STEP3;
            SEQ_STEP3: exp_stage = SEQ_STEP4;
            SEQ_STEP4: begin
               exp_stage = SEQ_STEP5;
               five = sel.sel_a | sel.sel_b;
            end
            SEQ_STEP5: exp_stage = five ? SEQ_START : SEQ_EXTRA;
            default: exp_stage = SEQ_START;
         endcase
         q.push_back(exp_stage);
      end
   end
   task automatic check(input stage_t e);
      samples_checked++;
      if (stage !== e || div !== {e[STAGE_FIRST_BIT], ~e[STAGE_FIRST_BIT]}) begin
         n_fail++;
         $display("CHECK FAILED stage/div expected %h seen %h/%b", e, stage, div);
      end
   endtask
   // outputs are settled mid-cycle
   always @(negedge i_clk_sys) begin
      if (q.size() > 0) begin
         check(q.pop_front());
      end
   end
   task automatic run(input logic [1:0] m, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge i_clk_sys);
         lfsr = lfsr_next(lfsr);
         mode <= m;
         rnd <= lfsr[1:0];
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // both low, random, feedback, both high, then a mid-run reset
   initial begin
      repeat (3) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      for (int m = 0; m < 4; m++) begin
         run(m[1:0], 60);
      end
      i_rst <= 1'b1;
      run(2'h1, 2);
      i_rst <= 1'b0;
      run(2'h1, 60);
      print_verdict();
   end
   // watchdog, the run needs about 305 cycles
   initial begin
      #50000;
      n_fail++;
      print_verdict();
   end
endmodule // testbench
